// >>> core/ccppwm_axil.sv
/*
  AXI4-Lite slave front end: one write and one read at a time,
  8-bit register strobes toward the core.
  Assumes the core answers rd_data combinationally from rd_addr.
*/
`timescale 1ns/1ps
`default_nettype none
module ccppwm_axil
  import ccppwm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data
);

  logic aw_rdy_ff, nxt_aw_rdy, w_rdy_ff, nxt_w_rdy, ar_rdy_ff, nxt_ar_rdy;
  logic bv_ff, nxt_bv, rv_ff, nxt_rv, wr_ff, nxt_wr, strb_ff, nxt_strb;
  logic [31:0] aw_ff, nxt_aw, rd_ff, nxt_rd;
  logic [7:0] wd_ff, nxt_wd;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;

  // Address and data are held until both are in, then one strobe
  always_comb begin
    nxt_aw_rdy = aw_rdy_ff;
    nxt_w_rdy = w_rdy_ff;
    nxt_ar_rdy = ar_rdy_ff;
    nxt_bv = bv_ff;
    nxt_rv = rv_ff;
    nxt_aw = aw_ff;
    nxt_wd = wd_ff;
    nxt_strb = strb_ff;
    nxt_br = br_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_wr = 1'b0;
    if (awvalid && aw_rdy_ff) begin
      nxt_aw_rdy = 1'b0;
      nxt_aw = awaddr;
    end
    if (wvalid && w_rdy_ff) begin
      nxt_w_rdy = 1'b0;
      nxt_wd = wdata[7:0];
      nxt_strb = wstrb[0];
    end
    if (!aw_rdy_ff && !w_rdy_ff && !bv_ff) begin
      nxt_bv = 1'b1;
      nxt_wr = strb_ff & ccppwm_addr_ok(aw_ff);
      nxt_br = ccppwm_addr_ok(aw_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_ff && bready) begin
      nxt_bv = 1'b0;
      nxt_aw_rdy = 1'b1;
      nxt_w_rdy = 1'b1;
    end
    // Read answers the cycle after the address is taken
    if (arvalid && ar_rdy_ff) begin
      nxt_ar_rdy = 1'b0;
      nxt_rv = 1'b1;
      nxt_rd = ccppwm_addr_ok(araddr) ? {24'h0, rd_data} : 32'h0;
      nxt_rr = ccppwm_addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rv_ff && rready) begin
      nxt_rv = 1'b0;
      nxt_ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_ff <= 1'b1;
      w_rdy_ff <= 1'b1;
      ar_rdy_ff <= 1'b1;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      wr_ff <= 1'b0;
      strb_ff <= 1'b0;
      aw_ff <= 32'h0;
      wd_ff <= 8'h00;
      br_ff <= RESP_OKAY;
      rd_ff <= 32'h0;
      rr_ff <= RESP_OKAY;
    end else begin
      aw_rdy_ff <= nxt_aw_rdy;
      w_rdy_ff <= nxt_w_rdy;
      ar_rdy_ff <= nxt_ar_rdy;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      wr_ff <= nxt_wr;
      strb_ff <= nxt_strb;
      aw_ff <= nxt_aw;
      wd_ff <= nxt_wd;
      br_ff <= nxt_br;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end

  assign awready = aw_rdy_ff;
  assign wready = w_rdy_ff;
  assign arready = ar_rdy_ff;
  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign rvalid = rv_ff;
  assign rresp = rr_ff;
  assign rdata = rd_ff;
  assign wr_en = wr_ff;
  assign wr_addr = aw_ff[4:0];
  assign wr_data = wd_ff;
  assign rd_addr = araddr[4:0];

endmodule
`default_nettype wire

// >>> core/ccppwm_presc.sv
/*
  Clock phase counter and timer prescaler; yields the timer increment
  pulse and the two low bits of the 10-bit time base.
  Assumes run and clr are synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ccppwm_presc
  import ccppwm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic clr,
  input wire logic [1:0] ps_sel,
  // Time base
  output logic tick,
  output logic [1:0] low2
);

  logic [1:0] q_ff, nxt_q;
  logic [3:0] pc_ff, nxt_pc;
  logic pc_last;

  // Phase counts four clocks, prescaler counts phase wraps
  always_comb begin
    pc_last = (ps_sel == PS_DIV1) ? 1'b1 :
              (ps_sel == PS_DIV4) ? (pc_ff[1:0] == PC_LAST4) :
              (pc_ff == PC_LAST16);
    nxt_q = q_ff;
    nxt_pc = pc_ff;
    if (clr) begin
      nxt_q = 2'h0;
      nxt_pc = 4'h0;
    end else if (run) begin
      nxt_q = q_ff + 2'h1;
      if (q_ff == PHASE_LAST) begin
        nxt_pc = pc_last ? 4'h0 : pc_ff + 4'h1;
      end
    end
    tick = run & ~clr & (q_ff == PHASE_LAST) & pc_last;
    // Clock phase at 1:1, prescaler's low two bits at 1:4, its top two bits at 1:16
    low2 = (ps_sel == PS_DIV1) ? q_ff :
           (ps_sel == PS_DIV4) ? pc_ff[1:0] : pc_ff[3:2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= 2'h0;
      pc_ff <= 4'h0;
    end else begin
      q_ff <= nxt_q;
      pc_ff <= nxt_pc;
    end
  end

endmodule
`default_nettype wire

// >>> core/ccppwm_top.sv
/*
  Standard PWM unit: period timer with prescaler, double-buffered
  10-bit duty, output pin and its direction, AXI4-Lite registers.
  Assumes one 40 MHz system clock; sleep_req is synchronous to it.
*/
// The implementer's own choices: the address map and register access over AXI4-Lite.
// What this block does
// - timer clears after matching the period value
// - period start sets pin unless duty zero
// - period start copies duty into shadow latches
// - duty is eight high plus two low bits
// - duty writes take effect next period
// - shadow duty read-only while in PWM
// - time base low bits from phase or prescaler
// - time base equal to duty clears pin
// - period is (limit+1) times 4 times prescale
// - prescaler divides by 1, 4 or 16
// - postscaler never affects the PWM period
// - duty above period leaves pin unchanged
// - sleep freezes timer, state and pin
// - reset restores registers, pin becomes input
// - mode 0000 off and resets, 11xx PWM
// - compare codes only decoded to a mode, no pin action
// - code 1011 only decoded as the special event mode
// - capture codes only decoded to a mode, nothing captured
`timescale 1ns/1ps
`default_nettype none
module ccppwm_top
  import ccppwm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Power state
  input wire logic sleep_req,
  // Output pin
  output logic pwm_output_pin,
  output logic pwm_output_oe
);

  // Register strobes from the bus
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;

  ccppwm_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Software-visible state
  logic [3:0] mode_ff, nxt_mode;
  logic [1:0] dlow_ff, nxt_dlow;
  logic [7:0] dhw_ff, nxt_dhw;
  logic [7:0] per_ff, nxt_per;
  logic [3:0] post_ff, nxt_post;
  logic [1:0] ps_ff, nxt_ps;
  logic run_ff, nxt_run;
  logic oe_ff, nxt_oe;
  logic tflag_ff, nxt_tflag;

  // Period and duty state
  logic [7:0] tmr_ff, nxt_tmr;
  logic [7:0] shd_ff, nxt_shd;
  logic [1:0] dlat_ff, nxt_dlat;
  logic lvl_ff, nxt_lvl;
  logic bnd_q_ff, nxt_bnd;

  // Decoded controls
  ccppwm_mode_t mode_dec;
  logic wr_uc, wr_dh, wr_shd, wr_per, wr_tc, wr_tcnt, wr_flg, wr_pin;
  logic pwm_on, unit_off, advance, presc_clr, tick, boundary, match;
  logic [1:0] low2;
  logic [9:0] tbase, duty_lat, duty_req;

  assign wr_uc = wr_en && (wr_addr == OFF_UNIT_CTRL);
  assign wr_dh = wr_en && (wr_addr == OFF_DUTY_HI);
  assign wr_shd = wr_en && (wr_addr == OFF_DUTY_SHD);
  assign wr_per = wr_en && (wr_addr == OFF_PERIOD);
  assign wr_tc = wr_en && (wr_addr == OFF_TMR_CTRL);
  assign wr_tcnt = wr_en && (wr_addr == OFF_TMR_CNT);
  assign wr_flg = wr_en && (wr_addr == OFF_FLAGS);
  assign wr_pin = wr_en && (wr_addr == OFF_PIN_CTRL);

  // Mode decode; capture and compare codes only name their mode here
  assign mode_dec = ccppwm_decode(mode_ff);
  assign pwm_on = (mode_dec == MD_PWM);
  assign unit_off = (mode_dec == MD_OFF);
  // Sleep gates the prescaler and the duty match, so timer and pin hold; bus register writes still take effect
  assign advance = run_ff & ~sleep_req;
  assign presc_clr = wr_tc | wr_tcnt;

  ccppwm_presc u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(advance),
    .clr(presc_clr),
    .ps_sel(ps_ff),
    .tick(tick),
    .low2(low2)
  );

  // Time base and duty compare
  assign boundary = tick && (tmr_ff == per_ff);
  assign tbase = {tmr_ff, low2};
  assign duty_lat = {shd_ff, dlat_ff};
  assign duty_req = {dhw_ff, dlow_ff};
  // A duty above the period never matches, pin keeps its level
  assign match = advance && (tbase == duty_lat);

  // Register writes; flag set wins over a same-cycle clear
  always_comb begin
    nxt_mode = mode_ff;
    nxt_dlow = dlow_ff;
    nxt_dhw = dhw_ff;
    nxt_per = per_ff;
    nxt_post = post_ff;
    nxt_ps = ps_ff;
    nxt_run = run_ff;
    nxt_oe = oe_ff;
    nxt_tflag = tflag_ff;
    if (wr_uc) begin
      nxt_mode = wr_data[UC_MODE_LSB +: 4];
      nxt_dlow = wr_data[UC_DLOW_LSB +: 2];
    end
    if (wr_dh) begin
      nxt_dhw = wr_data;
    end
    if (wr_per) begin
      nxt_per = wr_data;
    end
    if (wr_tc) begin
      nxt_ps = wr_data[TC_PS_LSB +: 2];
      nxt_run = wr_data[TC_RUN_BIT];
      // Stored for software only, never feeds the period logic
      nxt_post = wr_data[TC_POST_LSB +: 4];
    end
    if (wr_pin) begin
      nxt_oe = ~wr_data[PIN_DIR_BIT];
    end
    if (wr_flg && wr_data[FLG_TMR_BIT]) begin
      nxt_tflag = 1'b0;
    end
    if (boundary) begin
      nxt_tflag = 1'b1;
    end
  end

  // Any reset: registers to defaults, pin back to input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= RST_UNIT_CTRL[UC_MODE_LSB +: 4];
      dlow_ff <= RST_UNIT_CTRL[UC_DLOW_LSB +: 2];
      dhw_ff <= RST_DUTY;
      per_ff <= RST_PERIOD;
      post_ff <= RST_TMR_CTRL[TC_POST_LSB +: 4];
      ps_ff <= RST_TMR_CTRL[TC_PS_LSB +: 2];
      run_ff <= RST_TMR_CTRL[TC_RUN_BIT];
      oe_ff <= 1'b0;
      tflag_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      dlow_ff <= nxt_dlow;
      dhw_ff <= nxt_dhw;
      per_ff <= nxt_per;
      post_ff <= nxt_post;
      ps_ff <= nxt_ps;
      run_ff <= nxt_run;
      oe_ff <= nxt_oe;
      tflag_ff <= nxt_tflag;
    end
  end

  // Timer, shadow duty and pin level
  always_comb begin
    nxt_tmr = tmr_ff;
    nxt_shd = shd_ff;
    nxt_dlat = dlat_ff;
    nxt_lvl = lvl_ff;
    // Period start, delayed one clock; held through sleep so it is not lost
    nxt_bnd = sleep_req ? bnd_q_ff : boundary;
    if (boundary) begin
      nxt_tmr = 8'h00;
    end else if (tick) begin
      nxt_tmr = tmr_ff + 8'h01;
    end
    if (wr_tcnt) begin
      nxt_tmr = wr_data;
    end
    if (unit_off) begin
      nxt_shd = RST_DUTY;
      nxt_dlat = 2'h0;
      nxt_lvl = 1'b0;
    end else if (pwm_on) begin
      // Double buffer: new duty only at the period start
      if (boundary) begin
        nxt_shd = dhw_ff;
        nxt_dlat = dlow_ff;
      end
      // Set one clock late so both pin edges lag the time base alike
      if (match) begin
        nxt_lvl = 1'b0;
      end else if (bnd_q_ff && !sleep_req) begin
        nxt_lvl = (duty_lat != 10'h000);
      end
    end else begin
      // Shadow belongs to software only outside PWM
      if (wr_shd) begin
        nxt_shd = wr_data;
      end
      nxt_lvl = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_ff <= RST_TMR_CNT;
      shd_ff <= RST_DUTY;
      dlat_ff <= 2'h0;
      lvl_ff <= 1'b0;
      bnd_q_ff <= 1'b0;
    end else begin
      tmr_ff <= nxt_tmr;
      shd_ff <= nxt_shd;
      dlat_ff <= nxt_dlat;
      lvl_ff <= nxt_lvl;
      bnd_q_ff <= nxt_bnd;
    end
  end

  assign pwm_output_pin = lvl_ff;
  assign pwm_output_oe = oe_ff;

  // Register read mux, unused bits read zero
  always_comb begin
    case (rd_addr)
      OFF_UNIT_CTRL: rd_data = {2'h0, dlow_ff, mode_ff};
      OFF_DUTY_HI: rd_data = dhw_ff;
      OFF_DUTY_SHD: rd_data = shd_ff;
      OFF_PERIOD: rd_data = per_ff;
      OFF_TMR_CTRL: rd_data = {1'b0, post_ff, run_ff, ps_ff};
      OFF_TMR_CNT: rd_data = tmr_ff;
      OFF_FLAGS: rd_data = {4'(mode_dec), 3'h0, tflag_ff};
      OFF_PIN_CTRL: rd_data = {7'h00, ~oe_ff};
      default: rd_data = 8'h00;
    endcase
  end

  // Check helper: cycles since last period start, no disturbance
  logic [14:0] pcnt_ff, nxt_pcnt, per_len;
  logic clean_ff, nxt_clean;

  always_comb begin
    per_len = ({7'h00, per_ff} + 15'h0001) <<
              ((ps_ff == PS_DIV1) ? 2 : (ps_ff == PS_DIV4) ? 4 : 6);
    nxt_pcnt = boundary ? 15'h0000 : pcnt_ff + 15'h0001;
    nxt_clean = clean_ff;
    if (boundary) begin
      nxt_clean = 1'b1;
    end
    if (wr_en || !advance) begin
      nxt_clean = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_ff <= 15'h0000;
      clean_ff <= 1'b0;
    end else begin
      pcnt_ff <= nxt_pcnt;
      clean_ff <= nxt_clean;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quiet_start;
    boundary && !wr_en && pwm_on;
  endsequence

  sequence s_duty_hit;
    pwm_on && !boundary && match;
  endsequence

  AST_PERIOD_WRAP: assert property (boundary && !wr_en |=> tmr_ff == 8'h00)
    else $error("timer did not restart after period match");
  AST_PIN_SET: assert property (s_quiet_start ##0 duty_req != 10'h000 ##1 !sleep_req
    |=> lvl_ff)
    else $error("pin not set at period start");
  AST_ZERO_DUTY: assert property (s_quiet_start ##0 duty_req == 10'h000 ##1 !sleep_req
    |=> !lvl_ff)
    else $error("pin set with zero duty");
  AST_LATCH: assert property (s_quiet_start |=> duty_lat == $past(duty_req))
    else $error("duty not copied at period start");
  AST_HOLD_DUTY: assert property (pwm_on && !boundary |=> $stable(duty_lat))
    else $error("latched duty changed inside a period");
  AST_MATCH_LOW: assert property (s_duty_hit |=> !lvl_ff ##1 !lvl_ff)
    else $error("pin not cleared on duty match");
  AST_SLEEP: assert property (sleep_req && !wr_en |=> $stable(tmr_ff) && $stable(lvl_ff))
    else $error("state moved during sleep");
  AST_PERIOD_LEN: assert property (boundary && clean_ff |-> pcnt_ff == per_len - 15'h0001)
    else $error("period length wrong");
  AST_FLAG: assert property (boundary |=> tflag_ff)
    else $error("timer flag not set at period start");
  AST_OFF: assert property (unit_off && !wr_en |=> duty_lat == 10'h000 && !lvl_ff)
    else $error("off mode did not reset the unit");

endmodule
`default_nettype wire

// >>> shared/ccppwm_pkg.sv
/*
  Package of the PWM unit: register map, field positions, reset values,
  mode decode and bus constants.
  Assumes the includer runs on a single system clock.
*/
package ccppwm_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_UNIT_CTRL = 5'h00;
  localparam logic [4:0] OFF_DUTY_HI = 5'h04;
  localparam logic [4:0] OFF_DUTY_SHD = 5'h08;
  localparam logic [4:0] OFF_PERIOD = 5'h0c;
  localparam logic [4:0] OFF_TMR_CTRL = 5'h10;
  localparam logic [4:0] OFF_TMR_CNT = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  localparam logic [4:0] OFF_PIN_CTRL = 5'h1c;

  // Field positions
  localparam int UC_MODE_LSB = 0;
  localparam int UC_DLOW_LSB = 4;
  localparam int TC_PS_LSB = 0;
  localparam int TC_RUN_BIT = 2;
  localparam int TC_POST_LSB = 3;
  localparam int FLG_TMR_BIT = 0;
  localparam int PIN_DIR_BIT = 0;

  // Values after reset
  localparam logic [7:0] RST_UNIT_CTRL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_TMR_CTRL = 8'h00;
  localparam logic [7:0] RST_TMR_CNT = 8'h00;

  // Prescale encodings and counter end points
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PC_LAST4 = 2'h3;
  localparam logic [3:0] PC_LAST16 = 4'hf;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MD_OFF, MD_RSVD, MD_CMP_TOGGLE, MD_CAP_FALL, MD_CAP_RISE, MD_CAP_4,
    MD_CAP_16, MD_CMP_SET, MD_CMP_CLR, MD_CMP_SWI, MD_CMP_SPECIAL, MD_PWM
  } ccppwm_mode_t;

  // Mode field to operating mode
  function automatic ccppwm_mode_t ccppwm_decode(input logic [3:0] m);
    case (m)
      4'h0: return MD_OFF;
      4'h2: return MD_CMP_TOGGLE;
      4'h4: return MD_CAP_FALL;
      4'h5: return MD_CAP_RISE;
      4'h6: return MD_CAP_4;
      4'h7: return MD_CAP_16;
      4'h8: return MD_CMP_SET;
      4'h9: return MD_CMP_CLR;
      4'ha: return MD_CMP_SWI;
      4'hb: return MD_CMP_SPECIAL;
      4'hc, 4'hd, 4'he, 4'hf: return MD_PWM;
      default: return MD_RSVD;
    endcase
  endfunction

  // Eight aligned words from offset zero are mapped
  function automatic logic ccppwm_addr_ok(input logic [31:0] a);
    return (a[31:5] == 27'h0) && (a[1:0] == 2'h0);
  endfunction

endpackage

// >>> verification/ccp_standard_pwm_unit_test.sv
/*
  Self-checking bench of the PWM unit over its AXI4-Lite registers.
  Assumes the package offsets and the one-cycle bus answers of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module ccp_standard_pwm_unit_test;
  import ccppwm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'h1;
  logic sleep_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pwm_output_pin, pwm_output_oe;
  logic [1:0] bresp, rresp;
  int n_rise, last_period, last_high, fail_count = 0, n_checks = 0, cyc = 0;
  localparam logic [3:0] MIDX [16] = '{4'h0, 4'h1, 4'h2, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hb, 4'hb, 4'hb};

  ccppwm_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sleep_req(sleep_req), .pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe));
  ccppwm_load load (.aclk(aclk), .pin(pwm_output_pin), .oe(pwm_output_oe),
    .n_rise(n_rise), .last_period(last_period), .last_high(last_high));

  // 40 MHz clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
    end
  end

  // Compare tasks
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: reg %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: resp %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: bit %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    n_checks++;
    if (g != e) begin
      fail_count++;
      $display("mismatch at %0t: count %0d exp %0d", $time, g, e);
    end
  endtask

  // Bus master: both write channels offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
    bit ar;
    ar = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ar && arready) begin
        ar = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wrk(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr({27'h0, a}, d, r);
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd({27'h0, a}, d, r);
    chk_resp(r, RESP_OKAY);
    chk_reg(d, e);
  endtask

  // Helpers for reset, period boundaries and the timer flag
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic rst_chk;
    chk_bit(pwm_output_pin, 1'b0);
    chk_bit(pwm_output_oe, 1'b0);
    rdc(OFF_UNIT_CTRL, RST_UNIT_CTRL);
    rdc(OFF_DUTY_SHD, RST_DUTY);
    rdc(OFF_PERIOD, RST_PERIOD);
    rdc(OFF_TMR_CTRL, RST_TMR_CTRL);
    rdc(OFF_TMR_CNT, RST_TMR_CNT);
    rdc(OFF_PIN_CTRL, 8'h01);
  endtask
  task automatic wait_rise(input int k);
    int n0;
    n0 = n_rise;
    while (n_rise < n0 + k) @(posedge aclk);
  endtask
  task automatic wait_flag;
    logic [7:0] d;
    logic [1:0] r;
    for (int i = 0; i < 300; i++) begin
      rd({27'h0, OFF_FLAGS}, d, r);
      if (d[FLG_TMR_BIT] === 1'b1) break;
    end
    chk_bit(d[FLG_TMR_BIT], 1'b1);
  endtask

  // Main sequence
  initial begin
    logic [7:0] d, c0;
    logic [1:0] r;
    int f, n0;
    do_reset;
    rst_chk;
    // Limit 3, duty {01,2}=6 at each prescale; postscaler set on the last pass
    for (int p = 0; p < 3; p++) begin
      f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wrk(OFF_PIN_CTRL, 8'h01);
      wrk(OFF_PERIOD, 8'h03);
      wrk(OFF_UNIT_CTRL, 8'h2c);
      wrk(OFF_DUTY_HI, 8'h01);
      wrk(OFF_FLAGS, 8'h01);
      wrk(OFF_TMR_CTRL, {1'b0, (p == 2) ? 4'hf : 4'h0, 1'b1, p[1:0]});
      wait_flag;
      wrk(OFF_PIN_CTRL, 8'h00);
      @(posedge aclk);
      chk_bit(pwm_output_oe, 1'b1);
      wait_rise(3);
      chk_cnt(last_period, 16 * f);
      chk_cnt(last_high, 6 * f);
    end
    // New duty held back until the period ends; shadow ignores writes
    wait_rise(1);
    wrk(OFF_DUTY_HI, 8'h02);
    rdc(OFF_DUTY_SHD, 8'h01);
    wrk(OFF_DUTY_SHD, 8'h55);
    rdc(OFF_DUTY_SHD, 8'h01);
    wait_rise(2);
    rdc(OFF_DUTY_SHD, 8'h02);
    chk_cnt(last_high, 160);
    // Zero duty keeps the pin low
    wrk(OFF_UNIT_CTRL, 8'h0c);
    wrk(OFF_DUTY_HI, 8'h00);
    repeat (600) @(posedge aclk);
    n0 = n_rise;
    repeat (300) @(posedge aclk);
    chk_cnt(n_rise, n0);
    chk_bit(pwm_output_pin, 1'b0);
    // Duty beyond the period never clears the pin
    wrk(OFF_DUTY_HI, 8'h20);
    repeat (600) @(posedge aclk);
    n0 = n_rise;
    repeat (300) @(posedge aclk);
    chk_cnt(n_rise, n0);
    chk_bit(pwm_output_pin, 1'b1);
    // Sleep freezes count and pin, wake resumes
    sleep_req <= 1'b1;
    rd({27'h0, OFF_TMR_CNT}, c0, r);
    repeat (150) @(posedge aclk);
    rdc(OFF_TMR_CNT, c0);
    chk_bit(pwm_output_pin, 1'b1);
    sleep_req <= 1'b0;
    repeat (150) @(posedge aclk);
    rd({27'h0, OFF_TMR_CNT}, d, r);
    chk_bit(d != c0, 1'b1);
    // Every mode code and its decoded index
    for (int m = 0; m < 16; m++) begin
      wrk(OFF_UNIT_CTRL, {4'h0, m[3:0]});
      rd({27'h0, OFF_FLAGS}, d, r);
      chk_reg({4'h0, d[7:4]}, {4'h0, MIDX[m]});
    end
    wrk(OFF_UNIT_CTRL, 8'h00);
    @(posedge aclk);
    chk_bit(pwm_output_pin, 1'b0);
    rdc(OFF_DUTY_SHD, 8'h00);
    // Unmapped addresses are refused
    wr(32'h20, 8'h11, r);
    chk_resp(r, RESP_SLVERR);
    rd(32'h22, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_reg(d, 8'h00);
    // Reset in mid-run
    wrk(OFF_PERIOD, 8'h07);
    do_reset;
    rst_chk;
    end_of_test;
  end
endmodule
`default_nettype wire

// >>> verification/ccppwm_load.sv
/*
  Load on the PWM output pin: measures period and high time in clocks.
  Assumes the pin is pulled down while the unit does not drive it.
*/
`timescale 1ns/1ps
`default_nettype none
module ccppwm_load (
  // Clock
  input wire logic aclk,
  // Pin as seen from the load
  input wire logic pin,
  input wire logic oe,
  // Measurements
  output var int n_rise,
  output var int last_period,
  output var int last_high
);
  logic lvl_q = 1'b0;
  int since = 0;
  // Pull-down wins while the driver is off, so no stale level leaks through
  wire logic lvl = oe ? pin : 1'b0;
  // Edge timing: rise to rise is the period, rise to fall the high time
  always @(posedge aclk) begin
    lvl_q <= lvl;
    since <= since + 1;
    if (lvl && !lvl_q) begin
      n_rise <= n_rise + 1;
      last_period <= since;
      since <= 1;
    end
    if (!lvl && lvl_q) begin
      last_high <= since;
    end
  end
endmodule
`default_nettype wire
